/* File: design/rsse_pkg.sv */
// Shared constants and types for the rotate/set/sleep execution block
package rsse_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_WREG = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0C;
  localparam logic [7:0] OFS_INDEX = 8'h10;
  localparam logic [7:0] OFS_MADDR = 8'h14;
  localparam logic [7:0] OFS_MDATA = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_WDT = 8'h20;

  // Control field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam int CTRL_WDT_BIT = 2;

  // Status field positions
  localparam int STAT_NEG_BIT = 0;
  localparam int STAT_ZERO_BIT = 1;
  localparam int STAT_PD_BIT = 2;
  localparam int STAT_TO_BIT = 3;
  localparam int STAT_SLEEP_BIT = 4;
  localparam int STAT_ILL_BIT = 5;

  // ****************************************************************
  // Opcodes and addressing
  // ****************************************************************
  localparam logic [5:0] ROT_PREFIX = 6'h10;
  localparam logic [6:0] SET_PREFIX = 7'h34;
  localparam logic [15:0] SLEEP_CODE = 16'h0003;
  localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [7:0] ALL_ONES = 8'hFF;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic TO_RST = 1'b1;
  localparam logic PD_RST = 1'b1;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [11:0] ADDR12_RST = 12'h000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WDT_TICK_NS = 1000;
  localparam int WDT_TICK_CYC = (WDT_TICK_NS / CLK_PERIOD_NS < 1) ? 1 :
                                WDT_TICK_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    RSSE_OP_NONE,
    RSSE_OP_ROT,
    RSSE_OP_SET,
    RSSE_OP_SLEEP
  } rsse_op_t;

  typedef struct packed {
    rsse_op_t op;
    logic dest;
    logic acc;
    logic [7:0] f;
  } rsse_instr_t;

  typedef enum logic {
    RSSE_RUN,
    RSSE_ASLEEP
  } rsse_state_t;

endpackage : rsse_pkg

/* File: design/rsse_addr_resolve.sv */
// Operand address resolver: access bank, banked and indexed offset modes
`timescale 1ns/10ps

module rsse_addr_resolve (
  input wire logic [7:0] f,
  input wire logic acc,
  input wire logic [3:0] bank,
  input wire logic ext_en,
  input wire logic [11:0] index_base,
  output logic [11:0] eff_addr,
  output logic indexed
);

  // ****************************************************************
  // Effective address
  // ****************************************************************
  // Indexed mode takes priority over the plain access bank
  always_comb begin
    indexed = ext_en && !acc && (f <= rsse_pkg::ACCESS_LIMIT);
    if (indexed) begin
      eff_addr = 12'(index_base + {4'h0, f});
    end else if (acc) begin
      eff_addr = {bank, f};
    end else if (f <= rsse_pkg::ACCESS_LIMIT) begin
      eff_addr = {4'h0, f};
    end else begin
      eff_addr = {rsse_pkg::ACCESS_HIGH_BANK, f};
    end
  end

endmodule : rsse_addr_resolve

/* File: design/rsse_exec.sv */
// Execution core for rotate-right, set-all-ones and sleep, APB controlled
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/10ps

// Overview of operation
// - Rotate right moves every bit one place down and bit 0 to bit 7, no carry.
// - Destination bit 0 sends the rotate result to W, 1 writes it back to the file.
// - Access bit 0 picks the fixed access bank, 1 uses the bank select register.
// - Extended set on, access bit 0 and address up to 5Fh selects indexed offset.
// - Set-all-ones writes FFh to the addressed file byte, banked like others.
// - Set-all-ones with access bit 1 takes its bank from the bank select register.
// - Sleep clears the watchdog counter and its postscaler to zero.
// - Sleep halts execution and stops the oscillator at the end of the cycle.
module rsse_exec #(
  parameter int MEM_AW = 5,
  parameter int WDT_W = 8,
  parameter int POST_W = 4,
  parameter int TICK_CYC = rsse_pkg::WDT_TICK_CYC
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [rsse_pkg::APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  output logic SLEEP_ACTIVE,
  output logic OSC_RUN
);

  localparam int MEM_DEPTH = 1 << MEM_AW;

  // ****************************************************************
  // State
  // ****************************************************************
  logic pready, next_pready;
  logic pslverr, next_pslverr;
  logic [31:0] prdata, next_prdata;
  logic ext_en, next_ext_en;
  logic wdt_en, next_wdt_en;
  logic [7:0] wreg, next_wreg;
  logic [3:0] bank_select_reg, next_bank_select_reg;
  logic [11:0] index_base, next_index_base;
  logic [11:0] mem_addr, next_mem_addr;
  logic [15:0] last_instr, next_last_instr;
  logic neg_flag, next_neg_flag;
  logic zero_flag, next_zero_flag;
  logic timeout_flag, next_timeout_flag;
  logic power_down_flag, next_power_down_flag;
  logic illegal, next_illegal;
  rsse_pkg::rsse_state_t state, next_state;
  logic osc_run, next_osc_run;
  logic [15:0] div_cnt, next_div_cnt;
  logic [WDT_W-1:0] watchdog_counter, next_watchdog_counter;
  logic [POST_W-1:0] postscaler, next_postscaler;
  logic [7:0] file_mem [MEM_DEPTH];
  logic [7:0] next_file_mem [MEM_DEPTH];

  // Shared write port of the file storage
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [7:0] mem_wd;

  logic access, wr, rd, exec, wdt_tick, wdt_expire, indexed;
  logic [11:0] eff_addr;
  logic [7:0] src, rot;
  rsse_pkg::rsse_instr_t instr;

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic rsse_pkg::rsse_instr_t decode(input logic [15:0] op);
    rsse_pkg::rsse_instr_t d;
    d.op = rsse_pkg::RSSE_OP_NONE;
    d.dest = op[9];
    d.acc = op[8];
    d.f = op[7:0];
    if (op[15:10] == rsse_pkg::ROT_PREFIX) begin
      d.op = rsse_pkg::RSSE_OP_ROT;
    end else if (op[15:9] == rsse_pkg::SET_PREFIX) begin
      d.op = rsse_pkg::RSSE_OP_SET;
    end else if (op == rsse_pkg::SLEEP_CODE) begin
      d.op = rsse_pkg::RSSE_OP_SLEEP;
    end
    return d;
  endfunction : decode

  // A transfer completes on the edge that sees pready high
  assign access = PSEL && PENABLE && pready;
  assign wr = access && PWRITE;
  assign rd = access && !PWRITE;
  assign instr = decode(PWDATA[15:0]);
  // A refused write was flagged one cycle earlier, so never executes
  assign exec = wr && (PADDR == rsse_pkg::OFS_INSTR) && !pslverr;

  rsse_addr_resolve u_addr (
    .f(instr.f),
    .acc(instr.acc),
    .bank(bank_select_reg),
    .ext_en(ext_en),
    .index_base(index_base),
    .eff_addr(eff_addr),
    .indexed(indexed)
  );

  // File storage is a small window; upper address bits alias
  assign src = file_mem[eff_addr[MEM_AW-1:0]];
  assign rot = {src[0], src[7:1]};

  // ****************************************************************
  // Watchdog tick divider
  // ****************************************************************
  // One-cycle enable pulse every TICK_CYC reference clocks
  assign wdt_tick = wdt_en && (div_cnt == 16'(TICK_CYC - 1));
  assign wdt_expire = wdt_tick && (&watchdog_counter) && (&postscaler);

  // ****************************************************************
  // Bus answer and register next values
  // ****************************************************************
  always_comb begin
    next_pready = PSEL && PENABLE && !pready;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    next_ext_en = ext_en;
    next_wdt_en = wdt_en;
    next_wreg = wreg;
    next_bank_select_reg = bank_select_reg;
    next_index_base = index_base;
    next_mem_addr = mem_addr;
    next_last_instr = last_instr;
    next_neg_flag = neg_flag;
    next_zero_flag = zero_flag;
    next_timeout_flag = timeout_flag;
    next_power_down_flag = power_down_flag;
    next_illegal = illegal;
    next_state = state;
    next_osc_run = osc_run;
    mem_we = 1'b0;
    mem_wa = mem_addr[MEM_AW-1:0];
    mem_wd = PWDATA[7:0];
    // Answer is prepared in the first access cycle
    if (next_pready) begin
      next_prdata = 32'h0000_0000;
      unique case (PADDR)
        rsse_pkg::OFS_CTRL: begin
          next_prdata[rsse_pkg::CTRL_EXT_BIT] = ext_en;
          next_prdata[rsse_pkg::CTRL_WDT_BIT] = wdt_en;
        end
        rsse_pkg::OFS_INSTR: begin
          next_prdata[15:0] = last_instr;
          // Execution is halted while asleep
          next_pslverr = PWRITE && (state == rsse_pkg::RSSE_ASLEEP);
        end
        rsse_pkg::OFS_WREG: next_prdata[7:0] = wreg;
        rsse_pkg::OFS_BANK: next_prdata[3:0] = bank_select_reg;
        rsse_pkg::OFS_INDEX: next_prdata[11:0] = index_base;
        rsse_pkg::OFS_MADDR: next_prdata[11:0] = mem_addr;
        rsse_pkg::OFS_MDATA: begin
          next_prdata[7:0] = file_mem[mem_addr[MEM_AW-1:0]];
        end
        rsse_pkg::OFS_STATUS: begin
          next_prdata[rsse_pkg::STAT_NEG_BIT] = neg_flag;
          next_prdata[rsse_pkg::STAT_ZERO_BIT] = zero_flag;
          next_prdata[rsse_pkg::STAT_PD_BIT] = power_down_flag;
          next_prdata[rsse_pkg::STAT_TO_BIT] = timeout_flag;
          next_prdata[rsse_pkg::STAT_SLEEP_BIT] =
            (state == rsse_pkg::RSSE_ASLEEP);
          next_prdata[rsse_pkg::STAT_ILL_BIT] = illegal;
        end
        rsse_pkg::OFS_WDT: begin
          next_prdata[WDT_W-1:0] = watchdog_counter;
          next_prdata[WDT_W+POST_W-1:WDT_W] = postscaler;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
    // Register writes; an errored write changes nothing
    if (wr && !pslverr) begin
      unique case (PADDR)
        rsse_pkg::OFS_CTRL: begin
          next_ext_en = PWDATA[rsse_pkg::CTRL_EXT_BIT];
          next_wdt_en = PWDATA[rsse_pkg::CTRL_WDT_BIT];
          if (PWDATA[rsse_pkg::CTRL_WAKE_BIT]) begin
            next_state = rsse_pkg::RSSE_RUN;
            next_osc_run = 1'b1;
          end
        end
        rsse_pkg::OFS_WREG: next_wreg = PWDATA[7:0];
        rsse_pkg::OFS_BANK: next_bank_select_reg = PWDATA[3:0];
        rsse_pkg::OFS_INDEX: next_index_base = PWDATA[11:0];
        rsse_pkg::OFS_MADDR: next_mem_addr = PWDATA[11:0];
        rsse_pkg::OFS_MDATA: mem_we = 1'b1;
        default: ;
      endcase
    end
    // Instruction execution
    if (exec) begin
      next_last_instr = PWDATA[15:0];
      next_illegal = 1'b0;
      mem_wa = eff_addr[MEM_AW-1:0];
      unique case (instr.op)
        rsse_pkg::RSSE_OP_ROT: begin
          next_neg_flag = rot[7];
          next_zero_flag = (rot == 8'h00);
          if (instr.dest) begin
            mem_we = 1'b1;
            mem_wd = rot;
          end else begin
            next_wreg = rot;
          end
        end
        rsse_pkg::RSSE_OP_SET: begin
          mem_we = 1'b1;
          mem_wd = rsse_pkg::ALL_ONES;
        end
        rsse_pkg::RSSE_OP_SLEEP: begin
          next_timeout_flag = 1'b1;
          next_power_down_flag = 1'b0;
          next_state = rsse_pkg::RSSE_ASLEEP;
          next_osc_run = 1'b0;
        end
        rsse_pkg::RSSE_OP_NONE: next_illegal = 1'b1;
      endcase
    end
    // Watchdog overflow wakes a sleeping core and reports a timeout;
    // a sleep in the same cycle clears the watchdog first, so it wins
    if (wdt_expire &&
        !(exec && (instr.op == rsse_pkg::RSSE_OP_SLEEP))) begin
      next_timeout_flag = 1'b0;
      if (state == rsse_pkg::RSSE_ASLEEP) begin
        next_state = rsse_pkg::RSSE_RUN;
        next_osc_run = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Watchdog next values
  // ****************************************************************
  // Sleep clear wins over a tick in the same cycle
  always_comb begin
    next_div_cnt = div_cnt;
    next_watchdog_counter = watchdog_counter;
    next_postscaler = postscaler;
    if (wdt_en) begin
      next_div_cnt = wdt_tick ? 16'h0000 : div_cnt + 16'h0001;
    end
    if (wdt_tick) begin
      next_watchdog_counter = watchdog_counter + 1'b1;
      if (&watchdog_counter) begin
        next_postscaler = postscaler + 1'b1;
      end
    end
    if (exec && (instr.op == rsse_pkg::RSSE_OP_SLEEP)) begin
      next_watchdog_counter = '0;
      next_postscaler = '0;
      next_div_cnt = 16'h0000;
    end
  end

  // ****************************************************************
  // File storage next values
  // ****************************************************************
  // One write port, selected per entry
  generate
    for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_mem
      always_comb begin
        next_file_mem[i] = file_mem[i];
        if (mem_we && (mem_wa == MEM_AW'(i))) begin
          next_file_mem[i] = mem_wd;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Storage holds no reset value worth keeping, but is cleared anyway
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        file_mem[i] <= 8'h00;
      end
    end else begin
      file_mem <= next_file_mem;
    end
  end

  // Control, status and bus answer registers
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ext_en <= 1'b0;
      wdt_en <= 1'b0;
      wreg <= rsse_pkg::WREG_RST;
      bank_select_reg <= rsse_pkg::BANK_RST;
      index_base <= rsse_pkg::ADDR12_RST;
      mem_addr <= rsse_pkg::ADDR12_RST;
      last_instr <= 16'h0000;
      neg_flag <= 1'b0;
      zero_flag <= 1'b0;
      timeout_flag <= rsse_pkg::TO_RST;
      power_down_flag <= rsse_pkg::PD_RST;
      illegal <= 1'b0;
      state <= rsse_pkg::RSSE_RUN;
      osc_run <= 1'b1;
      div_cnt <= 16'h0000;
      watchdog_counter <= '0;
      postscaler <= '0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      ext_en <= next_ext_en;
      wdt_en <= next_wdt_en;
      wreg <= next_wreg;
      bank_select_reg <= next_bank_select_reg;
      index_base <= next_index_base;
      mem_addr <= next_mem_addr;
      last_instr <= next_last_instr;
      neg_flag <= next_neg_flag;
      zero_flag <= next_zero_flag;
      timeout_flag <= next_timeout_flag;
      power_down_flag <= next_power_down_flag;
      illegal <= next_illegal;
      state <= next_state;
      osc_run <= next_osc_run;
      div_cnt <= next_div_cnt;
      watchdog_counter <= next_watchdog_counter;
      postscaler <= next_postscaler;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // All outputs come straight from flip-flops
  assign PREADY = pready;
  assign PSLVERR = pslverr;
  assign PRDATA = prdata;
  assign SLEEP_ACTIVE = (state == rsse_pkg::RSSE_ASLEEP);
  assign OSC_RUN = osc_run;

endmodule : rsse_exec

/* File: sim/rsse_exec_properties.sv */
// Port-level properties of the rotate/set/sleep execution block
`timescale 1ns/10ps

module rsse_exec_properties (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [rsse_pkg::APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  input wire logic SLEEP_ACTIVE,
  input wire logic OSC_RUN
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  // ****************************************************************
  // Transfer shapes
  // ****************************************************************
  // Completion edge of any transfer, then the sleep and wake writes
  sequence s_done;
    PSEL && PENABLE && PREADY;
  endsequence
  sequence s_sleep_done;
    s_done ##0 (PWRITE && PADDR == rsse_pkg::OFS_INSTR && !PSLVERR &&
      PWDATA[15:0] == rsse_pkg::SLEEP_CODE);
  endsequence
  sequence s_wake_done;
    s_done ##0 (PWRITE && PADDR == rsse_pkg::OFS_CTRL && PWDATA[1]);
  endsequence

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_ready_one_wait: assert property ($rose(PENABLE) && PSEL |->
    !PREADY ##1 PREADY) else $error("ready not after one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error flag without ready");
  a_unmapped_err: assert property (s_done ##0 (PADDR > rsse_pkg::OFS_WDT ||
    PADDR[1:0] != 2'b00) |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  a_sleep_enter: assert property (
    s_sleep_done |=> SLEEP_ACTIVE && !OSC_RUN)
    else $error("sleep opcode did not stop the core");
  a_osc_stopped: assert property (OSC_RUN != SLEEP_ACTIVE)
    else $error("oscillator state disagrees with sleep state");
  a_asleep_refuse: assert property (
    s_done ##0 (PWRITE && PADDR == rsse_pkg::OFS_INSTR &&
    $past(SLEEP_ACTIVE)) |-> PSLVERR)
    else $error("instruction accepted while asleep");
  a_sleep_flags: assert property (
    s_done ##0 (!PWRITE && PADDR == rsse_pkg::OFS_STATUS && PRDATA[4])
    |-> PRDATA[3:2] == 2'b10) else $error("status flags wrong asleep");
  a_wake_ctrl: assert property (s_wake_done |=> !SLEEP_ACTIVE && OSC_RUN)
    else $error("wake write did not restart the core");
endmodule : rsse_exec_properties

/* File: sim/tb_top.sv */
// Self-checking testbench for the rotate/set/sleep execution block
`timescale 1ns/10ps

module tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [rsse_pkg::APB_AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic sleep_active;
  logic osc_run;
  logic [31:0] q;
  logic e;
  int error_cnt = 0;
  int checked = 0;

  // Clock; short watchdog counts keep the overflow within a few cycles
  always #5 ref_clk = ~ref_clk;

  rsse_exec #(.MEM_AW(12), .WDT_W(2), .POST_W(1), .TICK_CYC(2)) DUT (
    .REF_CLK(ref_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .SLEEP_ACTIVE(sleep_active),
    .OSC_RUN(osc_run));

  // ****************************************************************
  // Bus and checking tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      report_and_stop();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic poke(input logic [11:0] a, input logic [7:0] d);
    wr(rsse_pkg::OFS_MADDR, {20'h0, a});
    wr(rsse_pkg::OFS_MDATA, {24'h0, d});
  endtask : poke

  task automatic peek(input logic [11:0] a);
    wr(rsse_pkg::OFS_MADDR, {20'h0, a});
    apb(1'b0, rsse_pkg::OFS_MDATA, 32'h0);
  endtask : peek

  task automatic exec(input logic [15:0] op);
    wr(rsse_pkg::OFS_INSTR, {16'h0, op});
  endtask : exec

  function automatic logic [15:0] rot(logic d, logic a, logic [7:0] f);
    return {rsse_pkg::ROT_PREFIX, d, a, f};
  endfunction : rot

  function automatic logic [15:0] set_all_ones_op(logic a, logic [7:0] f);
    return {rsse_pkg::SET_PREFIX, a, f};
  endfunction : set_all_ones_op

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Banked rotate both ways, then the fixed access bank overriding bank
  task automatic t_rotate();
    wr(rsse_pkg::OFS_BANK, 32'h3);
    poke(12'h3A5, 8'hD7);
    exec(rot(1'b1, 1'b1, 8'hA5));
    peek(12'h3A5);
    check("rot file", q, 32'hEB);
    exec(rot(1'b0, 1'b1, 8'hA5));
    apb(1'b0, rsse_pkg::OFS_WREG, 32'h0);
    check("rot w", q, 32'hF5);
    peek(12'h3A5);
    check("rot source", q, 32'hEB);
    poke(12'hFA5, 8'h01);
    exec(rot(1'b1, 1'b0, 8'hA5));
    peek(12'hFA5);
    check("rot access", q, 32'h80);
    peek(12'h3A5);
    check("banked kept", q, 32'hEB);
    $display("rotate test done");
  endtask : t_rotate

  // Indexed offset only at or below the limit, and only when enabled
  task automatic t_indexed();
    poke(12'h010, 8'h02);
    exec(rot(1'b1, 1'b0, 8'h10));
    peek(12'h010);
    check("access low", q, 32'h01);
    wr(rsse_pkg::OFS_CTRL, 32'h1);
    wr(rsse_pkg::OFS_INDEX, 32'h200);
    poke(12'h210, 8'h04);
    exec(rot(1'b1, 1'b0, 8'h10));
    peek(12'h210);
    check("indexed", q, 32'h02);
    peek(12'h010);
    check("access kept", q, 32'h01);
    poke(12'h25F, 8'h08);
    exec(rot(1'b1, 1'b0, 8'h5F));
    peek(12'h25F);
    check("index limit", q, 32'h04);
    poke(12'hF60, 8'h10);
    exec(rot(1'b1, 1'b0, 8'h60));
    peek(12'hF60);
    check("above limit", q, 32'h08);
    exec(set_all_ones_op(1'b0, 8'h5F));
    peek(12'h25F);
    check("set indexed", q, 32'hFF);
    wr(rsse_pkg::OFS_CTRL, 32'h0);
    $display("indexed test done");
  endtask : t_indexed

  // Set all ones through the bank register and through the access bank
  task automatic t_set();
    wr(rsse_pkg::OFS_BANK, 32'h5);
    poke(12'h522, 8'h00);
    poke(12'h322, 8'h00);
    exec(set_all_ones_op(1'b1, 8'h22));
    peek(12'h522);
    check("set banked", q, 32'hFF);
    peek(12'h322);
    check("other bank", q, 32'h00);
    poke(12'h022, 8'h5A);
    exec(set_all_ones_op(1'b0, 8'h22));
    peek(12'h022);
    check("set access", q, 32'hFF);
    $display("set test done");
  endtask : t_set

  // Watchdog overflow first clears the timeout flag so sleep must set it
  task automatic t_sleep();
    wr(rsse_pkg::OFS_CTRL, 32'h4);
    repeat (40) @(posedge ref_clk);
    wr(rsse_pkg::OFS_CTRL, 32'h0);
    poke(12'hFF0, 8'h01);
    exec(rot(1'b1, 1'b0, 8'hF0));
    exec(rsse_pkg::SLEEP_CODE);
    check("sleep err", {31'h0, e}, 32'h0);
    @(negedge ref_clk);
    check("asleep", {31'h0, sleep_active}, 32'h1);
    check("osc", {31'h0, osc_run}, 32'h0);
    apb(1'b0, rsse_pkg::OFS_STATUS, 32'h0);
    check("status", q, 32'h19);
    apb(1'b0, rsse_pkg::OFS_WDT, 32'h0);
    check("wdt", q, 32'h0);
    poke(12'h033, 8'h00);
    exec(set_all_ones_op(1'b0, 8'h33));
    check("halted err", {31'h0, e}, 32'h1);
    peek(12'h033);
    check("halted", q, 32'h00);
    wr(rsse_pkg::OFS_CTRL, 32'h2);
    @(negedge ref_clk);
    check("awake", {31'h0, sleep_active}, 32'h0);
    check("osc on", {31'h0, osc_run}, 32'h1);
    $display("sleep test done");
  endtask : t_sleep

  // Unmapped and misaligned addresses are refused with zero data
  task automatic t_bus();
    apb(1'b0, 8'h24, 32'h0);
    check("unmapped err", {31'h0, e}, 32'h1);
    check("unmapped data", q, 32'h0);
    wr(8'h05, 32'hFFFF_FFFF);
    check("misaligned err", {31'h0, e}, 32'h1);
    exec(16'hFFFF);
    apb(1'b0, rsse_pkg::OFS_STATUS, 32'h0);
    check("illegal", q, 32'h29);
    $display("bus test done");
  endtask : t_bus

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, rsse_pkg::OFS_STATUS, 32'h0);
    check("reset status", q, 32'h0C);
    t_rotate();
    t_indexed();
    t_set();
    t_sleep();
    t_bus();
    report_and_stop();
  end
endmodule : tb_top

// Property checker on the top module's ports
bind rsse_exec rsse_exec_properties u_props (
  .REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PRDATA(PRDATA), .PSLVERR(PSLVERR), .SLEEP_ACTIVE(SLEEP_ACTIVE),
  .OSC_RUN(OSC_RUN));
